/* design/sadc_defs.svh */
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// register indices, byte address is four times the index
`define SADC_IDX_RESULT 8'hD0
`define SADC_IDX_CTRL 8'hD1
`define SADC_IDX_OPT 8'hD2

// control and option register bit layout, control register reset value
`define SADC_CTRL_RST 8'h40
`define SADC_B_IE 7
`define SADC_B_DONE 6
`define SADC_B_KICK 5
`define SADC_B_PWR 4
`define SADC_B_SYNC 0

// step clock and conversion timing
`define SADC_OSC_DIV 12
`define SADC_OSC_KHZ 8000
`define SADC_CONV_NS 70000
`define SADC_TICK_NS (`SADC_OSC_DIV * 1000000 / `SADC_OSC_KHZ)
`define SADC_CONV_TICKS (`SADC_CONV_NS / `SADC_TICK_NS)
`define SADC_SAR_BITS 8

// bus responses
`define SADC_RESP_OK 2'h0
`define SADC_RESP_ERR 2'h2

`endif

/* design/sadc_pkg.sv */
package sadc_pkg;

    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_ARM = 2'b01,
        SADC_CONV = 2'b10
    } sadc_state_e;

    typedef enum logic [1:0] {
        SADC_SEL_NONE = 2'b00,
        SADC_SEL_RES = 2'b01,
        SADC_SEL_CTRL = 2'b10,
        SADC_SEL_OPT = 2'b11
    } sadc_sel_e;

    typedef logic [11:0] sadc_addr_t;

    typedef struct packed {
        sadc_state_e state;
        logic ie;
        logic done;
        logic pwr;
        logic sync;
        logic [7:0] result;
        logic [7:0] work;
        logic [2:0] bit_idx;
        logic [7:0] tick_cnt;
        logic aw_have;
        sadc_addr_t aw_addr;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } sadc_st_s;

    typedef struct packed {
        logic [3:0] cnt;
    } sadc_div_s;

endpackage : sadc_pkg

/* design/sadc_step_div.sv */
`timescale 1ns/100ps
`include "sadc_defs.svh"

module sadc_step_div #(
    parameter int unsigned DIV = `SADC_OSC_DIV
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_restart,
    output logic o_tick
);

    localparam logic [3:0] LAST = 4'(DIV - 1);

    sadc_pkg::sadc_div_s s_q;
    sadc_pkg::sadc_div_s s_d;

    ////////////////////////////////////////////////////////////////////////////
    // divide by twelve, restart aligns the step grid to each conversion start
    always_comb begin
        s_d = s_q;
        if (i_restart || s_q.cnt == LAST) begin
            s_d.cnt = 4'h0;
        end else begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = (s_q.cnt == LAST);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    tick_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (o_tick ##1 !i_restart [*8] ##1 !i_restart [*3]) |=> o_tick)
        else $error("step tick period is not twelve");

endmodule : sadc_step_div

/* design/sadc_ctrl.sv */
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "sadc_defs.svh"

module sadc_ctrl #(
    parameter int unsigned CONV_TICKS = `SADC_CONV_TICKS
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_cpu_wait,
    input wire logic i_cmp_hi,
    output logic [7:0] o_dac_code,
    output logic o_ana_power,
    output logic o_conv_busy,
    output logic o_irq_conv
);

    localparam logic [7:0] LAST = 8'(CONV_TICKS - 1);
    localparam logic [7:0] FIRST = 8'(CONV_TICKS - `SADC_SAR_BITS);

    localparam logic [7:0] CTRL_RST = `SADC_CTRL_RST;
    localparam sadc_pkg::sadc_st_s ST_RST = '{
        state: sadc_pkg::SADC_IDLE,
        ie: CTRL_RST[`SADC_B_IE],
        done: CTRL_RST[`SADC_B_DONE],
        pwr: CTRL_RST[`SADC_B_PWR],
        default: '0
    };

    sadc_pkg::sadc_st_s s_q;
    sadc_pkg::sadc_st_s s_d;
    logic kick;
    logic tick;
    logic div_restart;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic sadc_pkg::sadc_sel_e sadc_sel(input sadc_pkg::sadc_addr_t a);
        logic [9:0] w;
        w = a[11:2];
        if (w == 10'(`SADC_IDX_RESULT)) begin
            return sadc_pkg::SADC_SEL_RES;
        end else if (w == 10'(`SADC_IDX_CTRL)) begin
            return sadc_pkg::SADC_SEL_CTRL;
        end else if (w == 10'(`SADC_IDX_OPT)) begin
            return sadc_pkg::SADC_SEL_OPT;
        end
        return sadc_pkg::SADC_SEL_NONE;
    endfunction : sadc_sel

    // fresh conversion: msb trial set, step counter cleared
    function automatic sadc_pkg::sadc_st_s sadc_start(input sadc_pkg::sadc_st_s s);
        sadc_pkg::sadc_st_s r;
        r = s;
        r.state = sadc_pkg::SADC_CONV;
        r.tick_cnt = 8'h00;
        r.work = 8'h80;
        r.bit_idx = 3'h7;
        return r;
    endfunction : sadc_start

    ////////////////////////////////////////////////////////////////////////////
    // step clock divider
    sadc_step_div #(
        .DIV(`SADC_OSC_DIV)
    ) i_sadc_step_div (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_restart(div_restart),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        kick = 1'b0;
        div_restart = 1'b0;

        // address and data taken in either order
        if (i_awvalid && !s_q.aw_have) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = i_awaddr;
        end
        if (i_wvalid && !s_q.w_have) begin
            s_d.w_have = 1'b1;
            s_d.w_data = i_wdata[7:0];
            s_d.w_lane = i_wstrb[0];
        end
        if (s_q.bvalid && i_bready) begin
            s_d.bvalid = 1'b0;
        end

        // write performed once both halves are held
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `SADC_RESP_OK;
            unique case (sadc_sel(s_q.aw_addr))
                sadc_pkg::SADC_SEL_RES: begin
                    s_d.bresp = `SADC_RESP_OK;
                end
                sadc_pkg::SADC_SEL_CTRL: begin
                    if (s_q.w_lane) begin
                        s_d.ie = s_q.w_data[`SADC_B_IE];
                        s_d.pwr = s_q.w_data[`SADC_B_PWR];
                        kick = s_q.w_data[`SADC_B_KICK];
                    end
                end
                sadc_pkg::SADC_SEL_OPT: begin
                    if (s_q.w_lane) begin
                        s_d.sync = s_q.w_data[`SADC_B_SYNC];
                    end
                end
                sadc_pkg::SADC_SEL_NONE: begin
                    s_d.bresp = `SADC_RESP_ERR;
                end
            endcase
        end

        // read answer
        if (s_q.rvalid && i_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (i_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `SADC_RESP_OK;
            unique case (sadc_sel(i_araddr))
                sadc_pkg::SADC_SEL_RES: begin
                    s_d.rdata = s_q.result;
                end
                sadc_pkg::SADC_SEL_CTRL: begin
                    s_d.rdata = {s_q.ie, s_q.done, 1'b0, s_q.pwr, 4'h0};
                end
                sadc_pkg::SADC_SEL_OPT: begin
                    s_d.rdata = {7'h00, s_q.sync};
                end
                sadc_pkg::SADC_SEL_NONE: begin
                    s_d.rdata = 8'h00;
                    s_d.rresp = `SADC_RESP_ERR;
                end
            endcase
        end

        // conversion engine
        unique case (s_q.state)
            sadc_pkg::SADC_IDLE: begin
                s_d.state = sadc_pkg::SADC_IDLE;
            end
            sadc_pkg::SADC_ARM: begin
                if (i_cpu_wait) begin
                    s_d = sadc_start(s_d);
                    div_restart = 1'b1;
                end
            end
            sadc_pkg::SADC_CONV: begin
                if (tick) begin
                    if (s_q.tick_cnt >= FIRST) begin
                        s_d.work[s_q.bit_idx] = i_cmp_hi;
                        if (s_q.bit_idx != 3'h0) begin
                            s_d.work[s_q.bit_idx - 3'h1] = 1'b1;
                        end
                        s_d.bit_idx = s_q.bit_idx - 3'h1;
                    end
                    if (s_q.tick_cnt == LAST) begin
                        s_d.result = s_d.work;
                        s_d.done = 1'b1;
                        s_d.state = sadc_pkg::SADC_IDLE;
                    end else begin
                        s_d.tick_cnt = s_q.tick_cnt + 8'h01;
                    end
                end
            end
            default: begin
                s_d.state = sadc_pkg::SADC_IDLE;
            end
        endcase

        // power down abandons any conversion
        if (!s_d.pwr) begin
            s_d.state = sadc_pkg::SADC_IDLE;
        end

        // kick wins over the engine, starts a conversion when powered, or arms first in sync mode outside wait
        if (kick) begin
            s_d.done = 1'b0;
            if (s_d.pwr) begin
                if (s_d.sync && !i_cpu_wait) begin
                    s_d.state = sadc_pkg::SADC_ARM;
                end else begin
                    s_d = sadc_start(s_d);
                    div_restart = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_awready = !s_q.aw_have;
    assign o_wready = !s_q.w_have;
    assign o_bvalid = s_q.bvalid;
    assign o_bresp = s_q.bresp;
    assign o_arready = !s_q.rvalid;
    assign o_rvalid = s_q.rvalid;
    assign o_rresp = s_q.rresp;
    assign o_rdata = {24'h000000, s_q.rdata};
    assign o_dac_code = s_q.work;
    assign o_ana_power = s_q.pwr;
    assign o_conv_busy = (s_q.state == sadc_pkg::SADC_CONV);
    assign o_irq_conv = s_q.ie & s_q.done;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    kick_clears_done_a: assert property (kick |=> !s_q.done)
        else $error("kick did not clear done");

    kick_restart_a: assert property (
        kick && s_d.pwr && (!s_d.sync || i_cpu_wait)
        |=> s_q.state == sadc_pkg::SADC_CONV && s_q.tick_cnt == 8'h00 && s_q.work == 8'h80)
        else $error("kick did not start a fresh conversion");

    done_on_finish_a: assert property (
        s_q.state == sadc_pkg::SADC_CONV && tick && s_q.tick_cnt == LAST && !kick && s_d.pwr
        |=> s_q.done && s_q.state == sadc_pkg::SADC_IDLE)
        else $error("finished conversion without done");

    no_autostart_a: assert property (
        s_q.state == sadc_pkg::SADC_IDLE && !kick |=> s_q.state == sadc_pkg::SADC_IDLE)
        else $error("conversion started without kick");

    kick_reads_zero_a: assert property (
        i_arvalid && o_arready && sadc_sel(i_araddr) == sadc_pkg::SADC_SEL_CTRL
        |=> !o_rdata[`SADC_B_KICK] && o_rdata[3:0] == 4'h0)
        else $error("kick bit or unused bits read back as one");

    result_read_a: assert property (
        i_arvalid && o_arready && sadc_sel(i_araddr) == sadc_pkg::SADC_SEL_RES
        |=> o_rdata == {24'h000000, $past(s_q.result)})
        else $error("result read does not match the stored value");

    irq_on_done_a: assert property (
        $rose(s_q.done) |-> o_irq_conv == s_q.ie)
        else $error("interrupt request not tied to done and enable");

    power_gate_a: assert property (
        s_q.state != sadc_pkg::SADC_IDLE |-> s_q.pwr && o_ana_power)
        else $error("converter active while powered down");

    wait_sync_a: assert property (
        s_q.state == sadc_pkg::SADC_ARM && !i_cpu_wait && !kick
        |=> s_q.state == sadc_pkg::SADC_ARM || s_q.state == sadc_pkg::SADC_IDLE)
        else $error("sync launch started before wait");

    result_hold_a: assert property (
        !$stable(s_q.result) |-> $rose(s_q.done) && $past(s_q.state) == sadc_pkg::SADC_CONV)
        else $error("result changed outside a completed conversion");

    result_ro_a: assert property (
        s_q.state != sadc_pkg::SADC_CONV |=> $stable(s_q.result))
        else $error("result changed by a write");

    irq_mask_a: assert property (!s_q.ie |-> !o_irq_conv)
        else $error("interrupt request while masked");

    done_holds_a: assert property (s_q.done && !kick |=> s_q.done)
        else $error("done flag dropped without a kick");

    power_abort_a: assert property (
        s_q.state != sadc_pkg::SADC_IDLE && !s_d.pwr |=> s_q.state == sadc_pkg::SADC_IDLE)
        else $error("power down did not abandon the conversion");

    kick_unpowered_a: assert property (
        kick && !s_d.pwr |=> s_q.state == sadc_pkg::SADC_IDLE && !s_q.done)
        else $error("kick without power started or left done set");

    arm_launch_a: assert property (
        s_q.state == sadc_pkg::SADC_ARM && i_cpu_wait && !kick && s_d.pwr
        |=> s_q.state == sadc_pkg::SADC_CONV && s_q.work == 8'h80)
        else $error("armed conversion did not launch in wait");

    step_hold_a: assert property (
        s_q.state == sadc_pkg::SADC_CONV && !tick && !kick |=> $stable(s_q.work))
        else $error("trial word moved between step ticks");

    restart_cover_c: cover property (s_q.state == sadc_pkg::SADC_CONV && kick);
    finish_cover_c: cover property ($rose(s_q.done));
    sync_cover_c: cover property (s_q.state == sadc_pkg::SADC_ARM ##1 s_q.state == sadc_pkg::SADC_CONV);
    irq_cover_c: cover property ($rose(o_irq_conv));

endmodule : sadc_ctrl

/* testbench/sadc_ana_model.sv */
`timescale 1ns/100ps

module sadc_ana_model (
    input wire logic [7:0] i_level,
    input wire logic [7:0] i_dac_code,
    output logic o_cmp_hi
);
    // one analog level at a time, compared with the dac code
    assign o_cmp_hi = (i_level >= i_dac_code);
endmodule : sadc_ana_model

/* testbench/sadc_ctrl_tb_top.sv */
`timescale 1ns/100ps
`include "sadc_defs.svh"

module sadc_ctrl_tb_top;
    localparam logic [11:0] A_RES = 12'(4 * `SADC_IDX_RESULT);
    localparam logic [11:0] A_CTL = 12'(4 * `SADC_IDX_CTRL);
    localparam logic [11:0] A_OPT = 12'(4 * `SADC_IDX_OPT);
    localparam logic [11:0] A_BAD = A_OPT + 12'h4;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic [11:0] awaddr = 12'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic cpu_wait = 1'b0;
    logic [7:0] level = 8'h0;
    logic [7:0] lv1;
    logic cmp_hi, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic o_ana_power, o_conv_busy, o_irq_conv;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [7:0] o_dac_code;
    logic [33:0] expq[$];
    logic [1:0] bq[$];
    int num_errors = 0;
    int n_compared = 0;

    sadc_ctrl #(.CONV_TICKS(10)) i_sadc_ctrl (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(rready),
        .i_cpu_wait(cpu_wait), .i_cmp_hi(cmp_hi), .o_dac_code(o_dac_code),
        .o_ana_power(o_ana_power), .o_conv_busy(o_conv_busy), .o_irq_conv(o_irq_conv)
    );

    sadc_ana_model i_sadc_ana_model (
        .i_level(level), .i_dac_code(o_dac_code), .o_cmp_hi(cmp_hi)
    );

    initial begin
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic timeout(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            conclude();
        end
    endtask : timeout

    // axi write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        logic ta, tw, tb;
        bq.push_back((a == A_RES || a == A_CTL || a == A_OPT) ? `SADC_RESP_OK : `SADC_RESP_ERR);
        @(posedge i_clk_sys);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        for (n = 0; n < 100 && !tb; n++) begin
            @(negedge i_clk_sys);
            ta = awvalid && o_awready;
            tw = wvalid && o_wready;
            tb = o_bvalid;
            @(posedge i_clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
        timeout(tb ? 0 : n, 100);
    endtask : wr

    // axi read, expected word noted before the request
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        logic ta, tr;
        expq.push_back({r, 24'h0, d});
        @(posedge i_clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 100 && !tr; n++) begin
            @(negedge i_clk_sys);
            ta = arvalid && o_arready;
            tr = o_rvalid;
            @(posedge i_clk_sys);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
        timeout(tr ? 0 : n, 100);
    endtask : rd

    task automatic flags(input logic [2:0] e);
        repeat (2) @(negedge i_clk_sys);
        chk({31'h0, o_conv_busy, o_irq_conv, o_ana_power}, {31'h0, e});
    endtask : flags

    task automatic wait_idle;
        int n;
        for (n = 0; n < 2000; n++) begin
            @(negedge i_clk_sys);
            if (!o_conv_busy) break;
        end
        timeout(n, 2000);
    endtask : wait_idle

    // read results and write responses taken off their queues at each handshake
    always @(posedge i_clk_sys) begin
        if (o_rvalid && rready) begin
            if (expq.size() == 0) begin
                chk({o_rresp, o_rdata}, 34'h3FFFFFFFF);
            end else begin
                chk({o_rresp, o_rdata}, expq.pop_front());
            end
        end
        if (o_bvalid && bready) begin
            if (bq.size() == 0) begin
                chk({32'h0, o_bresp}, 34'h3FFFFFFFF);
            end else begin
                chk({32'h0, o_bresp}, {32'h0, bq.pop_front()});
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hDA94AD1A));
        repeat (20) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        wr(A_BAD, 8'hFF);
        rd(A_CTL, 8'h40, `SADC_RESP_OK);
        rd(A_RES, 8'h00, `SADC_RESP_OK);
        rd(A_BAD, 8'h00, `SADC_RESP_ERR);
        wr(A_CTL, 8'h10);
        level <= 8'($urandom);
        wr(A_CTL, 8'hB0);
        flags(3'b101);
        rd(A_CTL, 8'h90, `SADC_RESP_OK);
        wr(A_CTL, 8'hB0);
        rd(A_RES, 8'h00, `SADC_RESP_OK);
        flags(3'b101);
        wait_idle();
        flags(3'b011);
        rd(A_CTL, 8'hD0, `SADC_RESP_OK);
        rd(A_RES, level, `SADC_RESP_OK);
        wr(A_RES, 8'h55);
        rd(A_RES, level, `SADC_RESP_OK);
        wr(A_CTL, 8'h10);
        flags(3'b001);
        repeat (150) @(negedge i_clk_sys);
        flags(3'b001);
        lv1 = level;
        wr(A_OPT, 8'h01);
        level <= 8'($urandom);
        wr(A_CTL, 8'h30);
        repeat (30) @(negedge i_clk_sys);
        flags(3'b001);
        rd(A_RES, lv1, `SADC_RESP_OK);
        @(posedge i_clk_sys);
        cpu_wait <= 1'b1;
        flags(3'b101);
        wait_idle();
        rd(A_RES, level, `SADC_RESP_OK);
        cpu_wait <= 1'b0;
        wr(A_CTL, 8'h20);
        flags(3'b000);
        rd(A_CTL, 8'h00, `SADC_RESP_OK);
        wr(A_OPT, 8'h00);
        wr(A_CTL, 8'h30);
        flags(3'b101);
        wr(A_CTL, 8'h00);
        flags(3'b000);
        rd(A_RES, level, `SADC_RESP_OK);
        wr(A_CTL, 8'h30);
        flags(3'b101);
        @(posedge i_clk_sys);
        i_arst_n <= 1'b0;
        flags(3'b000);
        @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        rd(A_CTL, 8'h40, `SADC_RESP_OK);
        repeat (4) @(negedge i_clk_sys);
        chk(34'(expq.size() + bq.size()), 34'h0);
        conclude();
    end
endmodule : sadc_ctrl_tb_top
